/* logic/serial_channel_pkg.sv */
// Shared constants, register layouts and types of the dual-mode serial channel.
package serial_channel_pkg;

	// Register byte offsets.
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_MODE = 4'h4;
	localparam logic [3:0] ADDR_CTRL = 4'h8;
	localparam logic [3:0] ADDR_STAT = 4'hc;

	// Frame formats.
	localparam logic [1:0] FMT_SHIFT = 2'h0;
	localparam logic [1:0] FMT_7     = 2'h1;
	localparam logic [1:0] FMT_8     = 2'h2;
	localparam logic [1:0] FMT_9     = 2'h3;

	// UART base clock sources.
	localparam logic [1:0] SRC_BAUD   = 2'h0;
	localparam logic [1:0] SRC_HALF   = 2'h1;
	localparam logic [1:0] SRC_TIMER2 = 2'h2;
	localparam logic [1:0] SRC_EXT    = 2'h3;

	// Bit positions in the control and status registers.
	localparam int CTRL_FE_BIT   = 4;
	localparam int CTRL_PE_BIT   = 5;
	localparam int CTRL_OE_BIT   = 6;
	localparam int CTRL_NINE_BIT = 7;
	localparam int STAT_RXP_BIT  = 0;
	localparam int STAT_TXP_BIT  = 1;
	localparam int STAT_FULL_BIT = 2;

	// Bit timing in base clock ticks, and the last shift I/O bit count.
	localparam logic [3:0] SAMPLE_A  = 4'h6;
	localparam logic [3:0] SAMPLE_B  = 4'h7;
	localparam logic [3:0] SAMPLE_C  = 4'h8;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] SIO_LAST  = 4'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       tx_ninth_bit;
		logic       clear_to_send_gate_enable;
		logic       receive_allow;
		logic       wake_up_filter;
		logic [1:0] frame_format_select;
		logic [1:0] uart_clock_source_select;
	} mode_reg_t;

	typedef struct packed {
		logic parity_enable;
		logic parity_even;
		logic sclk_direction_in;
		logic shift_edge_select;
	} ctrl_reg_t;

	localparam mode_reg_t MODE_RST = 8'h00;
	localparam ctrl_reg_t CTRL_RST = 4'h0;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage : serial_channel_pkg

/* logic/dual_mode_serial_channel.sv */
// Dual-mode serial channel: UART or clocked shift I/O behind an AXI4-Lite register slave.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Driven shift clock toggles on each baud tick, so it runs at half that rate.
// R2: With clock pin as input, the selected external edge forms the shift clock.
// R3: UART base clock picks baud tick, half system clock, timer 2 or pin.
// R4: Receive counter counts 16 ticks per bit; ticks 7-9 sampled, majority decides.
// R5: A start bit needs two low samples of three, otherwise it is noise.
// R6: Driven clock: sample input and advance output on its rising edge.
// R7: External clock: sample and shift on the edge that shift_edge_select picks.
// R8: Bits collect in a shift register, then move to the read buffer with interrupt.
// R9: Frame arriving while buffer unread sets overrun and is dropped, buffer kept.
// R10: Reading the data buffer clears the receive pending flag.
// R11: rx_ninth_bit holds received parity in 8-bit mode, ninth bit in 9-bit.
// R12: With wake-up filter in 9-bit mode only ninth-bit-one frames interrupt.
// R13: Transmit counter gives one tx_bit_tick every 16 base clock ticks.
// R14: Transmission starts at the tx_bit_tick after a write, with shift pulses.
// R15: Clear-to-send high holds the next frame until a tick after it falls.
// R16: Data leaves LSB first; buffer empties and transmit interrupt fires.
// R17: Parity exists only in 7 and 8 bit modes, even or odd selectable.
// R18: Transmit parity sits in bit 7 slot or ninth bit position.
// R19: Received parity compared against computed parity; mismatch sets parity error.
// R20: Stop bit sampled three times; majority low sets framing error.
// R21: Receive interrupt at last bit centre or stop centre; transmit before stop.
// R22: Shift mode moves 8 bits per write; interrupts after last clock edge.
// R23: Software picks the frame format with frame_format_select.
// R24: Software sets receive_allow before anything is received.
// R25: Software handles the ninth bit before the data buffer.
// R26: UART frames carry one low start bit and one high stop bit.
// R27: Error flags stay set until software clears them.
module dual_mode_serial_channel
	import serial_channel_pkg::*;
#(
	parameter bit HAS_EXT_CLOCK = 1'b1,
	parameter bit HAS_CTS       = 1'b1
) (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels.
	input  wire logic [3:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels.
	input  wire logic [3:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Clock sources.
	input  wire logic        baud_tick,
	input  wire logic        timer2_match,
	// Serial pins.
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	input  wire logic        shift_clock_in,
	output logic             shift_clock_out,
	output logic             shift_clock_oe,
	input  wire logic        clear_to_send_pin,
	// Events.
	output logic             receive_irq,
	output logic             transmit_irq,
	output logic             tx_bit_tick,
	output logic             tx_shift_pulse
);

	mode_reg_t   mode;
	ctrl_reg_t   ctrl;
	rx_state_t   rx_st;
	logic        aw_hold, w_hold, do_write;
	logic [3:0]  aw_addr;
	logic [7:0]  w_data;
	logic        w_lane;
	logic        wr_data, wr_mode, wr_ctrl, wr_stat, rd_data;
	logic [2:0]  err_clr;
	logic [7:0]  rd_mux;
	logic        rd_ok;
	logic        is_uart, half_phase, sclk_prev, sclk_rise, sclk_fall, base_tick;
	logic [3:0]  frame_bits;
	logic [7:0]  rx_data;
	logic        rx_ninth_bit, rx_pending, tx_pending;
	logic        overrun_flag, parity_error_flag, framing_error_flag;
	logic [3:0]  rx_cnt, rx_idx;
	logic [1:0]  rx_samp;
	logic [8:0]  rx_sh;
	logic        samp_done, vote, rx_last;
	logic        xfer_go, rx_set, wake_block, par_on, parity_error_flag_hit;
	logic [8:0]  xfer_word;
	logic [3:0]  tx_cnt, tx_left;
	logic [7:0]  tx_data;
	logic [10:0] tx_sh;
	logic [8:0]  tx_d9;
	logic        tx_full, cts_hold, tx_load, tx_irq_uart, tx_irq_set;
	logic        sio_act, sio_tx_on, sio_ev, sio_done, sio_start;
	logic [3:0]  sio_cnt;
	logic [7:0]  sio_tx, sio_rx;

	// Register slave.
	assign awready  = !aw_hold && !bvalid;
	assign wready   = !w_hold && !bvalid;
	assign arready  = !rvalid;
	assign do_write = aw_hold && w_hold && !bvalid;
	assign wr_data  = do_write && w_lane && aw_addr == ADDR_DATA;
	assign wr_mode  = do_write && w_lane && aw_addr == ADDR_MODE;
	assign wr_ctrl  = do_write && w_lane && aw_addr == ADDR_CTRL;
	assign wr_stat  = do_write && w_lane && aw_addr == ADDR_STAT;
	assign err_clr  = wr_ctrl ? w_data[CTRL_OE_BIT:CTRL_FE_BIT] : 3'h0;
	assign rd_data  = arvalid && arready && araddr == ADDR_DATA;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 8'h00;
			w_lane  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_hold <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold <= 1'b1;
				w_data <= wdata[7:0];
				w_lane <= wstrb[0];
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 8'h00;
		unique case (araddr)
			ADDR_DATA: rd_mux = rx_data;
			ADDR_MODE: rd_mux = mode;
			ADDR_CTRL: rd_mux = {rx_ninth_bit, overrun_flag, parity_error_flag, framing_error_flag, ctrl};
			ADDR_STAT: rd_mux = {5'h00, tx_full, tx_pending, rx_pending};
			default:   rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_mux};
			rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode <= MODE_RST;
			ctrl <= CTRL_RST;
		end else begin
			if (wr_mode)
				mode <= w_data;
			if (wr_ctrl)
				ctrl <= w_data[3:0];
		end
	end

	// Clock generation.
	assign is_uart   = mode.frame_format_select != FMT_SHIFT;
	assign sclk_rise = shift_clock_in && !sclk_prev;
	assign sclk_fall = !shift_clock_in && sclk_prev;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_phase <= 1'b0;
			sclk_prev  <= 1'b1;
		end else begin
			half_phase <= !half_phase;
			sclk_prev  <= shift_clock_in;
		end
	end

	always_comb begin
		unique case (mode.uart_clock_source_select) // R3
			SRC_BAUD:   base_tick = baud_tick;
			SRC_HALF:   base_tick = half_phase;
			SRC_TIMER2: base_tick = timer2_match;
			SRC_EXT:    base_tick = HAS_EXT_CLOCK && sclk_rise;
		endcase
	end

	always_comb begin
		unique case (mode.frame_format_select) // R23
			FMT_7:   frame_bits = ctrl.parity_enable ? 4'h8 : 4'h7;
			FMT_8:   frame_bits = ctrl.parity_enable ? 4'h9 : 4'h8;
			FMT_9:   frame_bits = 4'h9;
			default: frame_bits = 4'h8;
		endcase
	end

	// UART receiver.
	assign samp_done = is_uart && base_tick && rx_st != RX_IDLE && rx_cnt == SAMPLE_C;
	assign vote      = (rx_samp[1] & rx_samp[0]) | ((rx_samp[1] | rx_samp[0]) & serial_in_pin); // R4
	assign rx_last   = rx_idx == frame_bits - 4'h1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st   <= RX_IDLE;
			rx_cnt  <= 4'h0;
			rx_idx  <= 4'h0;
			rx_samp <= 2'h0;
			rx_sh   <= 9'h000;
		end else if (!is_uart) begin
			rx_st  <= RX_IDLE;
			rx_cnt <= 4'h0;
		end else if (base_tick) begin
			rx_cnt <= rx_cnt + 4'h1; // R4
			if (rx_cnt == SAMPLE_A || rx_cnt == SAMPLE_B)
				rx_samp <= {rx_samp[0], serial_in_pin};
			unique case (rx_st)
				RX_IDLE: begin
					rx_idx <= 4'h0;
					if (!serial_in_pin && mode.receive_allow) begin // R24
						rx_st  <= RX_START;
						rx_cnt <= 4'h1;
					end else begin
						rx_cnt <= 4'h0;
					end
				end
				RX_START: begin
					if (samp_done)
						rx_st <= vote ? RX_IDLE : RX_DATA; // R5
				end
				RX_DATA: begin
					if (samp_done) begin
						rx_sh[rx_idx] <= vote; // R8
						rx_idx        <= rx_idx + 4'h1;
						if (rx_last)
							rx_st <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (samp_done)
						rx_st <= RX_IDLE;
				end
			endcase
		end
	end

	// Receive buffer and flags.
	always_comb begin
		xfer_go   = 1'b0;
		xfer_word = rx_sh;
		if (sio_done && mode.receive_allow) begin // R22
			xfer_go   = 1'b1;
			xfer_word = {1'b0, serial_in_pin, sio_rx[7:1]};
		end else if (samp_done && rx_st == RX_DATA && rx_last && frame_bits == 4'h9) begin // R21
			xfer_go   = 1'b1;
			xfer_word = {vote, rx_sh[7:0]};
		end else if (samp_done && rx_st == RX_STOP && frame_bits != 4'h9) begin // R21
			xfer_go = 1'b1;
		end
	end

	assign wake_block = mode.frame_format_select == FMT_9 && mode.wake_up_filter && !xfer_word[8]; // R12
	assign rx_set     = xfer_go && !rx_pending && !wake_block;
	assign par_on     = ctrl.parity_enable && (mode.frame_format_select == FMT_7 ||
	                    mode.frame_format_select == FMT_8); // R17
	assign parity_error_flag_hit   = (mode.frame_format_select == FMT_7) ?
	                    (^xfer_word[7:0]) ^ !ctrl.parity_even :
	                    (^xfer_word[8:0]) ^ !ctrl.parity_even; // R19

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data      <= 8'h00;
			rx_ninth_bit <= 1'b0;
			receive_irq  <= 1'b0;
		end else begin
			receive_irq <= rx_set; // R8
			if (rx_set) begin
				if (mode.frame_format_select == FMT_7)
					rx_data <= {xfer_word[7] & par_on, xfer_word[6:0]};
				else
					rx_data <= xfer_word[7:0];
				rx_ninth_bit <= (frame_bits == 4'h9) && xfer_word[8]; // R11
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_pending         <= 1'b0;
			overrun_flag       <= 1'b0;
			parity_error_flag  <= 1'b0;
			framing_error_flag <= 1'b0;
		end else begin
			if (rd_data)
				rx_pending <= 1'b0; // R10
			if (rx_set)
				rx_pending <= 1'b1;
			if (err_clr[0])
				framing_error_flag <= 1'b0;
			if (err_clr[1])
				parity_error_flag <= 1'b0;
			if (err_clr[2])
				overrun_flag <= 1'b0;
			if (xfer_go && rx_pending)
				overrun_flag <= 1'b1; // R9 R27
			if (rx_set && par_on && parity_error_flag_hit)
				parity_error_flag <= 1'b1; // R19 R27
			if (samp_done && rx_st == RX_STOP && !vote)
				framing_error_flag <= 1'b1; // R20 R27
		end
	end

	// UART transmitter.
	assign tx_bit_tick = is_uart && base_tick && tx_cnt == TICK_LAST; // R13
	assign cts_hold    = HAS_CTS && mode.clear_to_send_gate_enable && clear_to_send_pin; // R15
	assign tx_load     = tx_bit_tick && tx_left <= 4'h1 && tx_full && !cts_hold; // R14 R15
	assign tx_shift_pulse = tx_bit_tick && tx_left > 4'h1; // R14
	assign tx_irq_uart = tx_bit_tick && tx_left == 4'h2; // R21
	assign tx_irq_set  = tx_irq_uart || (sio_done && sio_tx_on);

	always_comb begin
		unique case (mode.frame_format_select) // R18
			FMT_7:   tx_d9 = {1'b1, ctrl.parity_enable ? (^tx_data[6:0]) ^ !ctrl.parity_even : 1'b1,
			                  tx_data[6:0]};
			FMT_8:   tx_d9 = {ctrl.parity_enable ? (^tx_data) ^ !ctrl.parity_even : 1'b1, tx_data};
			default: tx_d9 = {mode.tx_ninth_bit, tx_data};
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cnt <= 4'h0;
			tx_left <= 4'h0;
			tx_sh  <= 11'h7ff;
		end else if (!is_uart) begin
			tx_cnt  <= 4'h0;
			tx_left <= 4'h0;
			tx_sh   <= 11'h7ff;
		end else if (base_tick) begin
			tx_cnt <= tx_cnt + 4'h1; // R13
			if (tx_load) begin
				tx_sh   <= {1'b1, tx_d9, 1'b0}; // R26
				tx_left <= frame_bits + 4'h2;
			end else if (tx_left > 4'h1 && tx_bit_tick) begin
				tx_sh   <= {1'b1, tx_sh[10:1]}; // R16
				tx_left <= tx_left - 4'h1;
			end else if (tx_bit_tick) begin
				tx_left <= 4'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_full      <= 1'b0;
			tx_data      <= 8'h00;
			tx_pending   <= 1'b0;
			transmit_irq <= 1'b0;
		end else begin
			transmit_irq <= tx_irq_set; // R16
			if (tx_irq_set)
				tx_full <= 1'b0; // R16
			if (wr_stat && w_data[STAT_TXP_BIT])
				tx_pending <= 1'b0;
			if (tx_irq_set)
				tx_pending <= 1'b1;
			if (wr_data) begin
				tx_full <= 1'b1;
				tx_data <= w_data;
			end
		end
	end

	// Shift I/O engine.
	assign sio_start = !is_uart && !sio_act && (tx_full || (mode.receive_allow && !rx_pending));
	assign sio_done  = sio_ev && sio_cnt == SIO_LAST; // R22
	always_comb begin
		if (!ctrl.sclk_direction_in)
			sio_ev = sio_act && baud_tick && !shift_clock_out; // R1 R6
		else
			sio_ev = sio_act && (ctrl.shift_edge_select ? sclk_fall : sclk_rise); // R2 R7
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sio_act         <= 1'b0;
			sio_tx_on       <= 1'b0;
			sio_cnt         <= 4'h0;
			sio_tx          <= 8'hff;
			sio_rx          <= 8'h00;
			shift_clock_out <= 1'b1;
		end else if (is_uart) begin
			sio_act         <= 1'b0;
			shift_clock_out <= 1'b1;
		end else begin
			if (!sio_act)
				shift_clock_out <= 1'b1;
			else if (baud_tick && !ctrl.sclk_direction_in)
				shift_clock_out <= !shift_clock_out; // R1
			if (sio_start) begin
				sio_act   <= 1'b1;
				sio_tx_on <= tx_full;
				sio_tx    <= tx_full ? tx_data : 8'hff;
				sio_cnt   <= 4'h0;
			end else if (sio_ev) begin
				sio_rx  <= {serial_in_pin, sio_rx[7:1]}; // R6 R7
				sio_tx  <= {1'b1, sio_tx[7:1]};
				sio_cnt <= sio_cnt + 4'h1;
				if (sio_done)
					sio_act <= 1'b0; // R22
			end
		end
	end

	assign shift_clock_oe = !is_uart && !ctrl.sclk_direction_in;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			serial_out_pin <= 1'b1;
		else
			serial_out_pin <= is_uart ? tx_sh[0] : sio_tx[0];
	end

	// Checks.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_sclk_half;
		$rose(shift_clock_out) && $past(sio_act) |-> $past(baud_tick);
	endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("shift clock edge without baud tick"); // R1

	property p_noise;
		rx_st == RX_START && samp_done && vote |=> rx_st == RX_IDLE;
	endproperty
	a_noise: assert property (p_noise) else $error("noisy start bit accepted"); // R5

	property p_tick_spacing;
		tx_bit_tick |=> !tx_bit_tick [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("bit ticks too close"); // R13

	property p_overrun;
		xfer_go && rx_pending && !err_clr[2] |=> overrun_flag && $stable(rx_data) && $stable(rx_ninth_bit);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not handled"); // R9

	property p_read_clear;
		rd_data && !rx_set |=> !rx_pending;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("data read left pending flag"); // R10

	property p_wake;
		receive_irq && mode.frame_format_select == FMT_9 && mode.wake_up_filter |-> rx_ninth_bit;
	endproperty
	a_wake: assert property (p_wake) else $error("wake filter passed a data frame"); // R12

	property p_cts;
		cts_hold && tx_left <= 4'h1 |=> tx_left <= 4'h1;
	endproperty
	a_cts: assert property (p_cts) else $error("frame started under clear-to-send hold"); // R15

	property p_frame_lsb;
		tx_load |=> tx_sh[0] == 1'b0 && tx_sh[1] == $past(tx_data[0]) && tx_sh[10];
	endproperty
	a_frame_lsb: assert property (p_frame_lsb) else $error("bad frame layout"); // R26

	property p_sticky;
		framing_error_flag && !err_clr[0] |=> framing_error_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("framing error dropped"); // R27

endmodule : dual_mode_serial_channel

`default_nettype wire

/* verif/serial_peer.sv */
// Peer controller and external shift register on the far side of the serial pins.
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
	parameter int BIT_CYCLES = 32
) (
	// Clock.
	input  wire logic aclk,
	// Serial lines.
	input  wire logic line_in,
	output logic      line_out,
	// Shift clock from the channel.
	input  wire logic sclk,
	input  wire logic sclk_oe
);
	logic [11:0] frame;
	logic [7:0]  shift_byte;
	int          nbits = 11;
	int          frames = 0;
	int          shift_edges = 0;

	initial line_out = 1'b1;

	// Sends a frame, first list entry first, then returns the line to idle high.
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			line_out <= bits[i];
			repeat (BIT_CYCLES - 1) @(posedge aclk);
		end
		@(posedge aclk);
		line_out <= 1'b1;
	endtask : send

	task automatic glitch(input int n);
		@(posedge aclk);
		line_out <= 1'b0;
		repeat (n) @(posedge aclk);
		line_out <= 1'b1;
	endtask : glitch

	// Samples each bit at its centre, start bit first.
	always begin : uart_rx
		@(negedge line_in);
		repeat (BIT_CYCLES / 2) @(posedge aclk);
		frame = 12'hfff;
		frame[0] = line_in;
		for (int i = 1; i < nbits; i++) begin
			repeat (BIT_CYCLES) @(posedge aclk);
			frame[i] = line_in;
		end
		frames++;
	end

	always @(posedge sclk) begin : shift_rx
		if (sclk_oe === 1'b1) begin
			shift_byte = {line_in, shift_byte[7:1]};
			shift_edges++;
		end
	end
endmodule : serial_peer
`default_nettype wire

/* verif/dual_mode_serial_channel_tb.sv */
// Self-checking bench for the dual-mode serial channel.
`timescale 1ns/1ps
`default_nettype none
module dual_mode_serial_channel_tb
	import serial_channel_pkg::*;
;
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic [3:0]       awaddr = 4'h0, araddr = 4'h0;
	logic [31:0]      wdata = 32'h0;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic             baud_tick = 1'b0, clear_to_send_pin = 1'b0, shift_clock_in = 1'b1;
	logic [1:0]       baud_cnt = 2'h0;
	wire logic        awready, wready, bvalid, arready, rvalid, serial_in_pin, serial_out_pin;
	wire logic        shift_clock_out, shift_clock_oe, receive_irq, transmit_irq, tx_shift_pulse;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	logic [11:0]      fr;
	logic [7:0]       sb;
	int               failures = 0, num_checks = 0, rx_irqs = 0, tx_irqs = 0, sft = 0, t0;

	dual_mode_serial_channel dual_mode_serial_channel_i (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .baud_tick(baud_tick), .timer2_match(1'b0),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .shift_clock_in(shift_clock_in),
		.shift_clock_out(shift_clock_out), .shift_clock_oe(shift_clock_oe), .clear_to_send_pin(clear_to_send_pin),
		.receive_irq(receive_irq), .transmit_irq(transmit_irq), .tx_bit_tick(), .tx_shift_pulse(tx_shift_pulse)
	);

	serial_peer serial_peer_i (
		.aclk(aclk), .line_in(serial_out_pin), .line_out(serial_in_pin),
		.sclk(shift_clock_out), .sclk_oe(shift_clock_oe)
	);

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		baud_cnt <= baud_cnt + 2'h1;
		baud_tick <= (baud_cnt == 2'h3);
		if (receive_irq === 1'b1) rx_irqs++;
		if (transmit_irq === 1'b1) tx_irqs++;
		if (tx_shift_pulse === 1'b1) sft++;
	end

	task automatic end_of_test();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic timed_out(input string what);
		failures++;
		$display("MISMATCH t=%0t timeout on %s", $time, what);
		end_of_test();
	endtask : timed_out

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Waits for one bus handshake: 0 read address, 1 read data, 2 write response.
	task automatic hs(input int sel, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic ok;
		ok = 1'b0;
		for (n = 0; n < 50 && ok !== 1'b1; n++) begin
			@(negedge aclk);
			ok = (sel == 0) ? arready : (sel == 1) ? rvalid : bvalid;
			d = rdata;
			r = (sel == 2) ? bresp : rresp;
			@(posedge aclk);
		end
		if (ok !== 1'b1) timed_out("bus");
	endtask : hs

	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		int          n;
		logic        aw_ok, w_ok, aw_pend, w_pend;
		logic [31:0] dd;
		logic [1:0]  r;
		n = 0;
		aw_pend = 1'b1;
		w_pend = 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_pend || w_pend) begin
			@(negedge aclk);
			aw_ok = awready;
			w_ok = wready;
			@(posedge aclk);
			if (aw_pend && aw_ok === 1'b1) begin
				aw_pend = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_pend && w_ok === 1'b1) begin
				w_pend = 1'b0;
				wvalid <= 1'b0;
			end
			n++;
			if (n > 50) timed_out("write");
		end
		hs(2, dd, r);
		check({30'h0, r}, {30'h0, er}, "write response");
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hs(0, d, r);
		arvalid <= 1'b0;
		hs(1, d, r);
		check({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
		check(d, exp, "read data");
	endtask : rd

	// Waits until a count reaches target: 0 receive irqs, 1 transmit irqs, 2 frames seen by the peer.
	task automatic wait_for(input int sel, input int target);
		int n;
		for (n = 0; n < 3000; n++) begin
			if ((sel == 0 ? rx_irqs : sel == 1 ? tx_irqs : serial_peer_i.frames) >= target) break;
			@(posedge aclk);
		end
		if (n == 3000) timed_out("event");
	endtask : wait_for

	// Start bit, data bits LSB first, optional parity, stop bits.
	function automatic logic [11:0] mk_frame(input logic [8:0] d, input int nd, input logic par, input logic odd);
		logic [11:0] f;
		logic        p;
		f = 12'hfff;
		f[0] = 1'b0;
		p = odd;
		for (int i = 0; i < nd; i++) begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		if (par) f[nd + 1] = p;
		return f;
	endfunction : mk_frame

	// A nonzero hold keeps clear-to-send high that long after the write, then lets it fall.
	task automatic tx_one(input logic [7:0] d, input int nd, input logic par, input logic odd, input int hold);
		int ti;
		int f1;
		int s0;
		ti = tx_irqs;
		s0 = sft;
		f1 = serial_peer_i.frames;
		serial_peer_i.nbits = nd + 2 + int'(par);
		wr(ADDR_DATA, d, RESP_OKAY);
		if (hold > 0) begin
			repeat (hold) @(posedge aclk);
			check(32'(serial_peer_i.frames - f1), 32'h0, "frame held back");
			clear_to_send_pin <= 1'b0;
		end
		wait_for(1, ti + 1);
		wait_for(2, f1 + 1);
		check({20'h0, serial_peer_i.frame}, {20'h0, mk_frame({1'b0, d}, nd, par, odd)}, "tx frame");
		check(32'(sft - s0), 32'(nd + 1 + int'(par)), "shift pulses");
	endtask : tx_one

	task automatic rx_one(input logic [11:0] bits, input int irqs);
		int r0;
		r0 = rx_irqs;
		serial_peer_i.send(bits, 11);
		repeat (40) @(posedge aclk);
		if (irqs >= 0) check(32'(rx_irqs - r0), 32'(irqs), "receive irq count");
	endtask : rx_one

	initial begin : main
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_MODE, 32'h0);
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_STAT, 32'h0);
		wr(4'h2, 8'h00, RESP_SLVERR);
		wr(ADDR_MODE, 8'h25, RESP_OKAY);
		wr(ADDR_CTRL, 8'h08, RESP_OKAY);
		tx_one(8'h35, 7, 1'b1, 1'b1, 0);
		wr(ADDR_MODE, 8'h29, RESP_OKAY);
		wr(ADDR_CTRL, 8'h0c, RESP_OKAY);
		tx_one(8'ha5, 8, 1'b1, 1'b0, 0);
		rd(ADDR_STAT, 32'h2);
		wr(ADDR_MODE, 8'h69, RESP_OKAY);
		clear_to_send_pin <= 1'b1;
		tx_one(8'h5c, 8, 1'b1, 1'b0, 500);
		wr(ADDR_MODE, 8'h29, RESP_OKAY);
		wr(ADDR_STAT, 8'h02, RESP_OKAY);
		t0 = rx_irqs;
		serial_peer_i.glitch(6);
		repeat (400) @(posedge aclk);
		check(32'(rx_irqs - t0), 32'h0, "noise pulse");
		rx_one(mk_frame(9'h03c, 8, 1'b1, 1'b0), 1);
		rd(ADDR_CTRL, 32'h0c);
		rd(ADDR_STAT, 32'h1);
		rd(ADDR_DATA, 32'h3c);
		rd(ADDR_STAT, 32'h0);
		rx_one(mk_frame(9'h03c, 8, 1'b1, 1'b1), 1);
		rd(ADDR_CTRL, 32'hac);
		rd(ADDR_DATA, 32'h3c);
		rx_one(mk_frame(9'h011, 8, 1'b1, 1'b0), 1);
		rx_one(mk_frame(9'h022, 8, 1'b1, 1'b1), -1);
		rd(ADDR_CTRL, 32'h6c);
		rd(ADDR_DATA, 32'h11);
		fr = mk_frame(9'h044, 8, 1'b1, 1'b0);
		fr[10] = 1'b0;
		rx_one(fr, 1);
		repeat (400) @(posedge aclk);
		rd(ADDR_CTRL, 32'h7c);
		rd(ADDR_DATA, 32'h44);
		wr(ADDR_CTRL, 8'h7c, RESP_OKAY);
		rd(ADDR_CTRL, 32'h0c);
		wr(ADDR_MODE, 8'h3d, RESP_OKAY);
		wr(ADDR_CTRL, 8'h00, RESP_OKAY);
		rx_one(mk_frame(9'h0a5, 9, 1'b0, 1'b0), 0);
		rx_one(mk_frame(9'h15a, 9, 1'b0, 1'b0), 1);
		rd(ADDR_CTRL, 32'h80);
		rd(ADDR_DATA, 32'h5a);
		wr(ADDR_MODE, 8'h00, RESP_OKAY);
		check({31'h0, shift_clock_oe}, 32'h1, "shift clock driven");
		serial_peer_i.shift_edges = 0;
		t0 = tx_irqs;
		wr(ADDR_DATA, 8'h96, RESP_OKAY);
		wait_for(1, t0 + 1);
		check({24'h0, serial_peer_i.shift_byte}, 32'h96, "shifted byte");
		check(32'(serial_peer_i.shift_edges), 32'h8, "shift clock edges");
		wr(ADDR_CTRL, 8'h03, RESP_OKAY);
		t0 = tx_irqs;
		wr(ADDR_DATA, 8'h5a, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			repeat (4) @(posedge aclk);
			sb = {serial_out_pin, sb[7:1]};
			shift_clock_in <= 1'b0;
			repeat (4) @(posedge aclk);
			shift_clock_in <= 1'b1;
		end
		wait_for(1, t0 + 1);
		check({24'h0, sb}, 32'h5a, "byte on external clock");
		end_of_test();
	end
endmodule : dual_mode_serial_channel_tb
`default_nettype wire
